// File: dsg_ahb_mem.sv
/*
   AHB-Lite word memory standing on the far side of the controller.
   Assumes one clock, word transfers and no pipelining by the master.
*/
module dsg_ahb_mem (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hready,
   output logic hresp,
   // Test controls
   input wire logic stall,
   input wire logic [31:0] err_addr
);
   // ------
   // Storage and data phase
   // ------
   // One flat area holds structures, task images and data.
   logic [31:0] mem [0:4095];
   logic dp_r, wr_r, errph_r, hit;
   logic [31:0] adr_r, last_r;

   // A faulting data phase gets the full two-cycle ERROR reply.
   assign hit = dp_r && adr_r == err_addr;
   assign hready = !dp_r || (hit ? errph_r : !stall);
   assign hresp = hit;
   // Outside a read data phase the bus flips every cycle, never old data.
   assign hrdata = (dp_r && !wr_r) ? mem[adr_r[13:2]] : ~last_r;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         dp_r <= 1'b0;
         wr_r <= 1'b0;
         errph_r <= 1'b0;
         adr_r <= 32'h0;
         last_r <= 32'h0;
      end else begin
         errph_r <= hit && !errph_r;
         last_r <= hrdata;
         if (dp_r && hready && wr_r && !hit) begin
            mem[adr_r[13:2]] <= hwdata;
         end
         if (hready) begin
            dp_r <= htrans[1];
            adr_r <= haddr;
            wr_r <= hwrite;
         end
      end
   end
endmodule // dsg_ahb_mem

// File: dsg_ctrl.sv
/*
   Peripheral scatter-gather channel controller: arbitration, control
   structure fetch and write-back, word transfers, error handling.
   Assumes an AHB-Lite slave on the master port and peripherals and a
   register master on the same clock, so no input is synchronised.
*/
`include "dsg_params.svh"

module dsg_ctrl #(
   parameter int NCH = 14
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // AHB-Lite master
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hready,
   input wire logic hresp,
   // Peripheral channels
   input wire logic [NCH-1:0] dma_req,
   output logic [NCH-1:0] dma_done,
   output logic [NCH-1:0] dma_active,
   output logic dma_err
);
   import dsg_pkg::*;

   // ------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] ent_addr(logic [21:0] b, logic a,
                                            logic [3:0] c, logic [3:0] o);
      ent_addr = {b, 1'b0, a, c, o}; // see [R13] [R14] [R15] [R18]
   endfunction

   function automatic logic [4:0] pick(logic [15:0] r);
      pick = 5'h00;
      for (int i = 15; i >= 0; i--) begin
         if (r[i]) begin
            pick = {1'b1, 4'(i)};
         end
      end
   endfunction

   function automatic logic is_data(st_t st);
      is_data = (st == S_FD) || (st == S_RD) || (st == S_WD) ||
                (st == S_BD);
   endfunction

   localparam logic [15:0] CH_MASK = 16'((32'h1 << NCH) - 32'h1);

   state_t s_r, s_nxt;
   logic [15:0] req;
   logic [4:0] sel;
   logic psg_pri;
   logic skipw;
   logic adv;
   logic ok_ack;
   logic [3:0] fetch_off;
   logic [31:0] src_a;
   logic [31:0] dst_a;
   logic [31:0] wb_word;
   logic [31:0] alt_base;
   logic [2:0] vcyc;
   logic [3:0] rp;

   // ------------------------------------------------------------
   // Derived values
   // ------------------------------------------------------------
   assign req = 16'(dma_req) & s_r.en;
   assign sel = pick(req);
   assign psg_pri = !s_r.alt && (s_r.cyc == `CC_PSG_PRI);
   // The fourth copied word would land on offset 0C, so it is not written.
   assign skipw = psg_pri && (s_r.nm1[1:0] == 2'h0); // see [R16]
   assign ok_ack = hready && !hresp;
   assign adv = ((s_r.st == S_WD) || ((s_r.st == S_RD) && skipw)) && ok_ack;
   assign fetch_off = (s_r.step == 2'h0) ? `OFF_CFG :
                      (s_r.step == 2'h1) ? `OFF_SRC : `OFF_DST;
   assign src_a = s_r.src - {20'h0, s_r.nm1, 2'h0};
   // Copy word k goes to alternate entry offset 4k, k = 3 - nm1[1:0].
   assign dst_a = psg_pri ?
      ent_addr(s_r.base, 1'b1, s_r.ch, {~s_r.nm1[1:0], 2'h0}) : // see [R4]
      s_r.dst - {20'h0, s_r.nm1, 2'h0};
   assign wb_word = {s_r.cfg[31:14], s_r.nm1, s_r.cfg[3],
                     s_r.fin ? `CC_INV : s_r.cyc}; // see [R7]
   assign alt_base = {s_r.base, 10'h0} + `ALT_OFS; // see [R17]
   assign vcyc = hrdata[2:0];
   assign rp = hrdata[17:14];

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 16'h0;
      s_nxt.err = 1'b0;
      case (s_r.st)
         S_IDLE: begin
            if (sel[4]) begin // see [R3] [R5]
               s_nxt.ch = sel[3:0];
               s_nxt.alt = s_r.altsel[sel[3:0]];
               s_nxt.step = 2'h0;
               s_nxt.st = S_FA;
            end
         end
         S_FA: begin
            if (hready) begin
               s_nxt.st = S_FD;
            end
         end
         S_FD: begin
            if (ok_ack) begin
               s_nxt.step = s_r.step + 2'h1;
               s_nxt.st = S_FA;
               if (s_r.step == 2'h0) begin
                  s_nxt.cfg = hrdata;
                  s_nxt.cyc = vcyc;
                  s_nxt.nm1 = hrdata[13:4];
                  s_nxt.fin = 1'b0;
                  if (!s_r.alt && vcyc == `CC_PSG_PRI) begin
                     s_nxt.rc = `PSG_ROUND; // see [R4]
                  end else if (rp >= `RP_FULL) begin
                     s_nxt.rc = `RC_FULL;
                  end else begin
                     s_nxt.rc = 10'((11'h1 << rp) - 11'h1);
                  end
                  if (!(vcyc == `CC_BASIC ||
                        (s_r.alt && vcyc == `CC_PSG_ALT) ||
                        (!s_r.alt && vcyc == `CC_PSG_PRI))) begin
                     // An invalid structure stops the channel.
                     s_nxt.en[s_r.ch] = 1'b0;
                     s_nxt.st = S_IDLE;
                  end
               end else if (s_r.step == 2'h1) begin
                  s_nxt.src = hrdata;
               end else begin
                  s_nxt.dst = hrdata;
                  s_nxt.st = S_RA;
               end
            end
         end
         S_RA: begin
            if (hready) begin
               s_nxt.st = S_RD;
            end
         end
         S_RD: begin
            if (ok_ack) begin
               s_nxt.data = hrdata;
               s_nxt.st = S_WA;
            end
         end
         S_WA: begin
            if (hready) begin
               s_nxt.st = S_WD;
            end
         end
         S_WD: begin
            s_nxt.st = S_WD;
         end
         S_BA: begin
            if (hready) begin
               s_nxt.st = S_BD;
            end
         end
         S_BD: begin
            if (ok_ack) begin
               s_nxt.st = S_IDLE;
               if (psg_pri) begin // see [R19]
                  s_nxt.altsel[s_r.ch] = 1'b1;
                  s_nxt.alt = 1'b1;
                  s_nxt.step = 2'h0;
                  s_nxt.st = S_FA;
               end else if (s_r.fin) begin
                  if (s_r.alt) begin
                     s_nxt.altsel[s_r.ch] = 1'b0; // see [R5]
                  end
                  if (s_r.cyc == `CC_BASIC) begin
                     s_nxt.done[s_r.ch] = 1'b1; // see [R8]
                     s_nxt.en[s_r.ch] = 1'b0; // see [R10]
                  end
               end
            end
         end
         default: begin
            s_nxt.st = S_IDLE;
         end
      endcase
      if (adv) begin
         s_nxt.fin = (s_r.nm1 == 10'h0);
         s_nxt.rc = s_r.rc - 10'h1;
         if (s_r.nm1 != 10'h0) begin
            s_nxt.nm1 = s_r.nm1 - 10'h1;
         end
         if (s_r.nm1 == 10'h0 || s_r.rc == 10'h0) begin
            s_nxt.st = S_BA;
         end else begin
            s_nxt.st = S_RA;
         end
      end
      if (is_data(s_r.st) && hresp) begin
         s_nxt.en[s_r.ch] = 1'b0; // see [R9]
         s_nxt.err = 1'b1;
         s_nxt.st = S_IDLE;
      end
      // Software enable writes come last, so a set wins over a clear.
      if (reg_wr) begin
         case (reg_addr)
            `REG_BASE: s_nxt.base = reg_wdata[31:`BASE_LSB]; // see [R17]
            `REG_EN_SET: s_nxt.en = s_nxt.en | (reg_wdata[15:0] & CH_MASK);
            `REG_EN_CLR: s_nxt.en = s_nxt.en & ~reg_wdata[15:0];
            default: s_nxt.en = s_nxt.en;
         endcase
      end
      s_nxt.rdata = 32'h0;
      if (reg_rd) begin
         case (reg_addr)
            `REG_STATUS: s_nxt.rdata = {27'h0, s_r.st != S_IDLE, s_r.ch};
            `REG_BASE: s_nxt.rdata = {s_r.base, 10'h0};
            `REG_ALT_BASE: s_nxt.rdata = alt_base;
            `REG_EN_SET: s_nxt.rdata = {16'h0, s_r.en};
            `REG_ALT_SEL: s_nxt.rdata = {16'h0, s_r.altsel};
            default: s_nxt.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // The base may be rewritten mid-transfer; software must not do so.
   always_comb begin
      haddr = 32'h0;
      htrans = `HTRANS_IDLE;
      hwrite = 1'b0;
      hwdata = 32'h0;
      case (s_r.st)
         S_FA: begin
            haddr = ent_addr(s_r.base, s_r.alt, s_r.ch, fetch_off);
            htrans = `HTRANS_NONSEQ;
         end
         S_RA: begin
            haddr = src_a;
            htrans = `HTRANS_NONSEQ;
         end
         S_WA: begin
            haddr = dst_a;
            htrans = `HTRANS_NONSEQ;
            hwrite = 1'b1;
         end
         S_WD: hwdata = s_r.data;
         S_BA: begin
            haddr = ent_addr(s_r.base, s_r.alt, s_r.ch, `OFF_CFG);
            htrans = `HTRANS_NONSEQ;
            hwrite = 1'b1;
         end
         S_BD: hwdata = wb_word;
         default: haddr = 32'h0;
      endcase
   end

   assign hsize = `HSIZE_WORD;
   assign reg_rdata = s_r.rdata;
   assign dma_done = s_r.done[NCH-1:0];
   assign dma_err = s_r.err;

   for (genvar i = 0; i < NCH; i++) begin : g_act
      assign dma_active[i] = (s_r.st != S_IDLE) && (s_r.ch == 4'(i));
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   AST_START_ON_REQ: assert property (@(posedge clk) disable iff (rst)
      (s_r.st == S_IDLE && req == 16'h0) |=> s_r.st == S_IDLE) // see [R3]
      else $error("Transfer started without a request.");

   AST_FOUR_COPIES: assert property (@(posedge clk) disable iff (rst)
      (s_r.st == S_FD && s_r.step == 2'h0 && ok_ack && !s_r.alt &&
       vcyc == `CC_PSG_PRI) |=> s_r.rc == 10'h3) // see [R4]
      else $error("Primary round is not four transfers.");

   AST_NO_AUTO: assert property (@(posedge clk) disable iff (rst)
      (s_r.st == S_BD && ok_ack && s_r.alt && s_r.fin &&
       s_r.cyc == `CC_PSG_ALT) |=> s_r.st == S_IDLE &&
       !s_r.altsel[s_r.ch]) // see [R5]
      else $error("Alternate task end did not return to arbitration.");

   AST_INVALIDATE: assert property (@(posedge clk) disable iff (rst)
      (s_r.st == S_BD && !s_r.alt && s_r.fin) |->
      hwdata[2:0] == 3'h0 && hwrite == 1'b0) // see [R7]
      else $error("Last primary copy did not invalidate structure.");

   AST_DONE_ONE: assert property (@(posedge clk) disable iff (rst)
      (dma_done != '0) |=> (dma_done == '0)) // see [R8]
      else $error("Done held longer than one cycle.");

   AST_DONE_BASIC: assert property (@(posedge clk) disable iff (rst)
      (s_r.st == S_BD && ok_ack && s_r.fin && !psg_pri &&
       s_r.cyc == `CC_BASIC) |=> s_r.done[s_r.ch] && s_r.st == S_IDLE)
      // see [R8]
      else $error("Basic cycle end gave no done pulse.");

   AST_ERR: assert property (@(posedge clk) disable iff (rst)
      (is_data(s_r.st) && hresp) |=> dma_err && !s_r.en[s_r.ch]) // see [R9]
      else $error("Bus error did not disable channel.");

   AST_DONE_DIS: assert property (@(posedge clk) disable iff (rst)
      (s_r.done != 16'h0 && !$past(reg_wr)) |->
      (s_r.done & s_r.en) == 16'h0) // see [R10]
      else $error("Channel still enabled after done.");

   AST_ADDR_MAP: assert property (@(posedge clk) disable iff (rst)
      (s_r.st == S_FA || s_r.st == S_BA) |-> haddr[8] == s_r.alt &&
      haddr[7:4] == s_r.ch && haddr[31:10] == s_r.base) // see [R13] [R18]
      else $error("Structure address malformed.");

   AST_NO_0C: assert property (@(posedge clk) disable iff (rst)
      (s_r.st == S_FA || s_r.st == S_BA || (s_r.st == S_WA && psg_pri))
      |-> haddr[3:2] != 2'h3) // see [R16]
      else $error("Unused structure word accessed.");

   AST_CHAIN: assert property (@(posedge clk) disable iff (rst)
      (s_r.st == S_BD && ok_ack && psg_pri) |=> s_r.st == S_FA &&
      s_r.alt && dma_active[s_r.ch]) // see [R19]
      else $error("Alternate cycle did not follow primary copy.");

   AST_ALT_BASE: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == `REG_ALT_BASE) |=>
      reg_rdata == {$past(s_r.base), 10'h0} + 32'h100) // see [R17]
      else $error("Alternate base readback wrong.");

endmodule // dsg_ctrl

// File: dsg_params.svh
/*
   Constants of the peripheral scatter-gather channel controller: register
   offsets, control structure layout, cycle codes and bus encodings.
   Assumes it is included by bare name, before any use of its macros.
*/
// How it works
// [R1] Software selects mode 110 with four-word rounds.
// [R2] Software stores task images before enabling channel.
// [R3] Transaction starts only on a peripheral request.
// [R4] Primary phase copies four words into alternate; the code reads four but writes only three, skipping offset 0C.
// [R5] Alternate task end returns to arbitration, no autorequest.
// [R6] Peripheral keeps requesting until long tasks finish.
// [R7] Last primary copy writes cycle code 000.
// [R8] Final basic task pulses done one cycle.
// [R9] Bus error disables channel and raises error.
// [R10] Done also clears that channel's enable.
// [R11] Software finds faulting channel from enables.
// [R12] Structure area contiguous, base aligned to size.
// [R13] Address bit 8 selects primary or alternate.
// [R14] Channel number sits on address bits 7..4.
// [R15] Offsets 00, 04, 08: source, destination, control.
// [R16] Offset 0C is never read or written.
// [R17] Base from register; alternate base readable separately.
// [R18] Low ten bits form addresses, base supplies rest.
// [R19] Alternate cycle follows primary copy without rearbitration.
// [R20] Software makes primary count a multiple of four.
`ifndef DSG_PARAMS_SVH
`define DSG_PARAMS_SVH

// ------------------------------------------------------------
// Register port offsets
// ------------------------------------------------------------
`define REG_STATUS 8'h00
`define REG_BASE 8'h08
`define REG_ALT_BASE 8'h0C
`define REG_EN_SET 8'h28
`define REG_EN_CLR 8'h2C
`define REG_ALT_SEL 8'h34

// ------------------------------------------------------------
// Control structure layout
// ------------------------------------------------------------
`define OFF_SRC 4'h0
`define OFF_DST 4'h4
`define OFF_CFG 4'h8
`define BASE_LSB 10
`define ALT_OFS 32'h0000_0100
`define MAX_CH 16

// ------------------------------------------------------------
// Control word fields and cycle codes
// ------------------------------------------------------------
`define CC_INV 3'h0
`define CC_BASIC 3'h1
`define CC_PSG_PRI 3'h6
`define CC_PSG_ALT 3'h7
`define PSG_ROUND 10'h003
`define RP_FULL 4'hA
`define RC_FULL 10'h3FF

// ------------------------------------------------------------
// Bus encodings
// ------------------------------------------------------------
`define HTRANS_IDLE 2'h0
`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD 3'h2

`endif

// File: dsg_pkg.sv
/*
   Types of the peripheral scatter-gather channel controller: the state
   enumeration and the packed state record.
   Assumes dsg_params.svh is on the include path.
*/
package dsg_pkg;
`include "dsg_params.svh"

   // ------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE, S_FA, S_FD, S_RA, S_RD, S_WA, S_WD, S_BA, S_BD
   } st_t;

   // ------------------------------------------------------------
   // Whole state of the controller
   // ------------------------------------------------------------
   typedef struct packed {
      st_t st;
      logic [3:0] ch;
      logic alt;
      logic [2:0] cyc;
      logic [9:0] nm1;
      logic [9:0] rc;
      logic [1:0] step;
      logic fin;
      logic [31:0] src;
      logic [31:0] dst;
      logic [31:0] cfg;
      logic [31:0] data;
      logic [21:0] base;
      logic [15:0] en;
      logic [15:0] altsel;
      logic [15:0] done;
      logic err;
      logic [31:0] rdata;
   } state_t;

endpackage

// File: tb_dma_scatter_gather_ctrl_table.sv
/*
   Self-checking bench of the scatter-gather channel controller.
   Assumes dsg_ctrl, dsg_pkg and the memory model dsg_ahb_mem.
*/
`include "dsg_params.svh"
module tb_dma_scatter_gather_ctrl_table;
   timeunit 1ns;
   timeprecision 1ns;
   import dsg_pkg::*;
   // ------
   // Signals
   // ------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic stall = 1'b0;
   // Channel 7 requests all run long but is never enabled.
   logic [13:0] dma_req = 14'h0080;
   logic [31:0] reg_rdata, haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hwrite, hready, hresp, dma_err;
   logic [13:0] dma_done, dma_active;
   logic [31:0] rnd = 32'h0000_0032;
   logic [31:0] src_q[$];
   int fail_count = 0, tests_run = 0, cycles = 0;
   int done_n = 0, err_n = 0, busy_n = 0;

   dsg_ctrl #(.NCH(14)) dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hrdata, .hready, .hresp, .dma_req, .dma_done, .dma_active, .dma_err);
   dsg_ahb_mem mem_i (.clk, .rst, .haddr, .htrans, .hwrite, .hwdata,
      .hrdata, .hready, .hresp, .stall, .err_addr(32'h0000_3000));

   always #50 clk = ~clk;

   // ------
   // Helpers
   // ------
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic put(input logic [31:0] a, input logic [31:0] d);
      mem_i.mem[a[13:2]] = d;
   endtask

   function automatic logic [31:0] peek(input logic [31:0] a);
      return mem_i.mem[a[13:2]];
   endfunction

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_check(input string n, input logic [7:0] a,
                            input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(n, e, reg_rdata);
      @(posedge clk);
      #1;
      chk("rdata_idle", 32'h0, reg_rdata);
   endtask

   // No bus traffic may appear while nothing is requested.
   task automatic quiet(input string n);
      int b;
      b = busy_n;
      repeat (16) @(posedge clk);
      #1;
      chk(n, b, busy_n);
   endtask

   // One request, held until the round starts, then dropped.
   task automatic serve(input int ch);
      int t;
      t = 0;
      @(posedge clk);
      dma_req[ch] <= 1'b1;
      #1;
      while (dma_active[ch] !== 1'b1 && t < 200) begin
         @(posedge clk);
         #1;
         t++;
      end
      chk("round_start", 32'h1, {31'h0, t < 200});
      @(posedge clk);
      dma_req[ch] <= 1'b0;
      #1;
      while (dma_active[ch] === 1'b1 && t < 2000) begin
         @(posedge clk);
         #1;
         t++;
      end
      chk("round_end", 32'h1, {31'h0, t < 2000});
      // The done or error pulse stands in this cycle; let the monitor count it.
      @(posedge clk);
      #1;
   endtask

   // Model of the destination: the first k words moved, the rest untouched.
   task automatic dst_chk(input int k);
      for (int i = 0; i < 6; i++) begin
         chk("dst", i < k ? src_q[i] : 32'h0,
             peek(32'h2000 + 4 * i));
      end
   endtask

   // ------
   // Monitor and timeout
   // ------
   always @(posedge clk) begin
      cycles <= cycles + 1;
      rnd <= xs(rnd);
      stall <= rnd[0];
      if (|dma_done) done_n <= done_n + 1;
      if (dma_err) err_n <= err_n + 1;
      if (htrans == `HTRANS_NONSEQ) begin
         busy_n <= busy_n + 1;
         chk("hsize", {29'h0, `HSIZE_WORD}, {29'h0, hsize});
         if (haddr[31:10] == 22'h1) begin
            chk("ctl_off", 32'h1, {31'h0, haddr[3:0] != 4'hC});
         end
      end
      if (cycles == 5000) begin
         fail_count++;
         end_sim();
      end
   end

   // ------
   // Main sequence
   // ------
   initial begin
      for (int i = 0; i < 12; i++) begin
         @(posedge clk);
         if (i < 6) src_q.push_back(rnd);
      end
      rst <= 1'b0;
      reg_check("en_rst", `REG_EN_SET, 32'h0);
      reg_check("base_rst", `REG_BASE, 32'h0);
      reg_write(`REG_BASE, 32'h0000_0400);
      reg_check("base", `REG_BASE, 32'h0000_0400);
      reg_check("alt_base", `REG_ALT_BASE, 32'h0000_0500);
      reg_check("unmapped", 8'h40, 32'h0);
      put(32'h0000_0430, 32'h0000_081C);
      put(32'h0000_0434, 32'h0000_053C);
      put(32'h0000_0438, 32'hAA00_8076);
      put(32'h0000_053C, 32'h5A5A_5A5A);
      put(32'h0000_0800, 32'h0000_1004);
      put(32'h0000_0804, 32'h0000_2004);
      put(32'h0000_0808, 32'hAA02_8017);
      put(32'h0000_080C, 32'h0BAD_0000);
      put(32'h0000_0810, 32'h0000_1014);
      put(32'h0000_0814, 32'h0000_2014);
      put(32'h0000_0818, 32'hAA00_4031);
      put(32'h0000_081C, 32'h0BAD_0001);
      for (int i = 0; i < 6; i++) begin
         put(32'h1000 + 4 * i, src_q[i]);
         put(32'h2000 + 4 * i, 32'h0);
      end
      put(32'h0000_0450, 32'h0000_3004);
      put(32'h0000_0454, 32'h0000_2104);
      put(32'h0000_0458, 32'hAA02_8011);
      put(32'h0000_3004, 32'h0000_0001);
      put(32'h0000_2100, 32'h0);
      reg_write(`REG_EN_SET, 32'h0000_0008);
      reg_check("en_set", `REG_EN_SET, 32'h0000_0008);
      quiet("no_req");
      reg_check("status", `REG_STATUS, 32'h0);
      serve(3);
      quiet("no_autoreq");
      dst_chk(2);
      chk("alt_unused", 32'h5A5A_5A5A, peek(32'h0000_053C));
      reg_check("alt_sel1", `REG_ALT_SEL, 32'h0);
      serve(3);
      quiet("no_autoreq2");
      dst_chk(4);
      reg_check("alt_sel2", `REG_ALT_SEL, 32'h0000_0008);
      chk("pri_code", 32'h0, peek(32'h0000_0438) & 32'h7);
      chk("no_done", 32'h0, done_n);
      serve(3);
      dst_chk(6);
      chk("done_once", 32'h1, done_n);
      reg_check("en_after", `REG_EN_SET, 32'h0);
      reg_write(`REG_EN_SET, 32'h0000_0020);
      serve(5);
      chk("err_pulse", 32'h1, err_n);
      reg_check("en_err", `REG_EN_SET, 32'h0);
      chk("err_done", 32'h1, done_n);
      chk("err_dst", 32'h0, peek(32'h0000_2100));
      reg_write(`REG_EN_SET, 32'h0000_0100);
      reg_write(`REG_EN_CLR, 32'h0000_0100);
      reg_check("en_clr", `REG_EN_SET, 32'h0);
      end_sim();
   end
endmodule // tb_dma_scatter_gather_ctrl_table
